// ### verilog/pmc_pkg.sv
// Shared constants and types of the power mode controller
package pmc_pkg;

	// ==========================================================
	// Operating modes
	typedef enum logic [1:0] {
		PMC_ACTIVE,
		PMC_STANDBY,
		PMC_SLEEP,
		PMC_STARTUP
	} pmc_mode_e;

	// ==========================================================
	// Widths and reset values
	localparam int PORTA_WIDTH = 4;
	localparam logic SLEEP_ARM_RST = 1'h0;
	localparam logic SLEEP_BIT_RST = 1'h0;
	localparam logic VLD_FINISH_RST = 1'h0;
	localparam logic SYNC_RST = 1'h0;

	// ==========================================================
	// Port A reset combination select per bit {sel1, sel2}
	localparam logic [1:0] PA_SEL_NEVER = 2'h0;
	localparam logic [1:0] PA_SEL_HIGH = 2'h1;
	localparam logic [1:0] PA_SEL_LOW = 2'h2;
	localparam logic [1:0] PA_SEL_ANY = 2'h3;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 5;
	// Least high time of the reset pin to leave sleep
	localparam int RST_PIN_MIN_NS = 10000;
	localparam int RST_PIN_CYCLES =
		(RST_PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Oscillator start-up hold, given in system clocks
	localparam int STARTUP_CLOCKS = 32768;

endpackage

// ### verilog/pmc_hold_counter.sv
// Run-length counter: done rises after COUNT consecutive run cycles
`timescale 1ns/10ps
module pmc_hold_counter #(
	parameter int COUNT = 16
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic run,
	output logic done
);

	localparam int W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LAST = W'(COUNT - 1);
	localparam logic [W-1:0] ZERO = W'(0);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} pmc_cnt_s;

	pmc_cnt_s q;
	pmc_cnt_s d;

	// ==========================================================
	// Next state
	// Dropping run restarts the count, so a glitchy level never
	// accumulates across gaps.
	always_comb begin
		d = q;
		if (clk_en) begin
			if (!run) begin
				d.cnt = ZERO;
				d.done = 1'h0;
			end else if (!q.done) begin
				d.cnt = q.cnt + W'(1);
				d.done = (q.cnt == LAST);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;

endmodule // pmc_hold_counter

// ### verilog/pmc_power_mode_controller.sv
// Operating-mode controller: active, standby, sleep and start-up hold
`timescale 1ns/10ps
module pmc_power_mode_controller #(
	parameter int STARTUP_CYCLES = pmc_pkg::STARTUP_CLOCKS,
	parameter int PA_W = pmc_pkg::PORTA_WIDTH
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic halt_exec,
	input wire logic irq_pending,
	input wire logic sys_reset_req,
	input wire logic wr_system_control_1,
	input wire logic wr_sleep_bit,
	input wire logic wr_system_control_2,
	input wire logic wr_sleep_arm,
	input wire logic reset_pin,
	input wire logic [PA_W-1:0] porta_pin,
	input wire logic [PA_W-1:0] porta_sel1,
	input wire logic [PA_W-1:0] porta_sel2,
	input wire logic porta_reset_in_sleep,
	input wire logic vld_busy,
	output pmc_pkg::pmc_mode_e mode,
	output logic sleep_arm,
	output logic sleep_bit,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_en,
	output logic sys_reset,
	output logic cpu_reset,
	output logic portb_sp_hiz,
	output logic porta_in_en,
	output logic porta_pull_en,
	output logic vld_en
);

	typedef struct packed {
		pmc_pkg::pmc_mode_e mode;
		logic sleep_arm;
		logic sleep_bit;
		logic vld_finish;
		logic rst_pin_m;
		logic rst_pin_s;
		logic [PA_W-1:0] pa_m;
		logic [PA_W-1:0] pa_s;
	} pmc_state_s;

	localparam pmc_state_s RST_STATE = '{
		mode: pmc_pkg::PMC_ACTIVE,
		sleep_arm: pmc_pkg::SLEEP_ARM_RST,
		sleep_bit: pmc_pkg::SLEEP_BIT_RST,
		vld_finish: pmc_pkg::VLD_FINISH_RST,
		rst_pin_m: pmc_pkg::SYNC_RST,
		rst_pin_s: pmc_pkg::SYNC_RST,
		pa_m: '0,
		pa_s: '0
	};

	pmc_state_s q;
	pmc_state_s d;

	logic [PA_W-1:0] pa_term;
	logic pa_match;
	logic pa_wake;
	logic pin_run;
	logic pin_wake;
	logic startup_run;
	logic startup_done;
	logic sleep_write_ok;
	logic in_active;
	logic in_standby;
	logic in_sleep;
	logic in_startup;

	// ==========================================================
	// Port A reset combination
	// Any bit on select "never" blocks the whole match.
	generate
		for (genvar i = 0; i < PA_W; i++) begin : g_pa
			always_comb begin
				case ({porta_sel1[i], porta_sel2[i]})
				pmc_pkg::PA_SEL_NEVER: pa_term[i] = 1'h0;
				pmc_pkg::PA_SEL_HIGH: pa_term[i] = q.pa_s[i];
				pmc_pkg::PA_SEL_LOW: pa_term[i] = ~q.pa_s[i];
				pmc_pkg::PA_SEL_ANY: pa_term[i] = 1'h1;
				default: pa_term[i] = 1'h0;
				endcase
			end
		end
	endgenerate

	assign pa_match = &pa_term;
	// No debouncer here: the oscillator is off in sleep
	assign pa_wake = in_sleep && porta_reset_in_sleep && pa_match;

	// ==========================================================
	// Wake filter on the reset pin and start-up hold
	assign pin_run = in_sleep && q.rst_pin_s;

	pmc_hold_counter #(
		.COUNT(pmc_pkg::RST_PIN_CYCLES)
	) u_pin_filter (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.run(pin_run),
		.done(pin_wake)
	);

	assign startup_run = in_startup;

	pmc_hold_counter #(
		.COUNT(STARTUP_CYCLES)
	) u_startup (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.run(startup_run),
		.done(startup_done)
	);

	// ==========================================================
	// Mode sequencing
	assign in_active = (q.mode == pmc_pkg::PMC_ACTIVE);
	assign in_standby = (q.mode == pmc_pkg::PMC_STANDBY);
	assign in_sleep = (q.mode == pmc_pkg::PMC_SLEEP);
	assign in_startup = (q.mode == pmc_pkg::PMC_STARTUP);
	// Arm must already hold 1; a same-cycle arm write does not count
	assign sleep_write_ok = wr_system_control_1 && wr_sleep_bit &&
		q.sleep_arm;

	always_comb begin
		d = q;
		if (clk_en) begin
			d.rst_pin_m = reset_pin;
			d.rst_pin_s = q.rst_pin_m;
			d.pa_m = porta_pin;
			d.pa_s = q.pa_m;
			// System resets leave the arm bit alone
			if (wr_system_control_2) begin
				d.sleep_arm = wr_sleep_arm;
			end
			case (q.mode)
			pmc_pkg::PMC_ACTIVE: begin
				if (sys_reset_req) begin
					d.mode = pmc_pkg::PMC_STARTUP;
					d.sleep_bit = 1'h0;
				end else if (sleep_write_ok) begin
					d.mode = pmc_pkg::PMC_SLEEP;
					d.sleep_bit = 1'h1;
				end else if (halt_exec) begin
					d.mode = pmc_pkg::PMC_STANDBY;
					d.vld_finish = vld_busy;
				end
			end
			pmc_pkg::PMC_STANDBY: begin
				if (sys_reset_req) begin
					d.mode = pmc_pkg::PMC_STARTUP;
					d.vld_finish = 1'h0;
				end else if (irq_pending) begin
					d.mode = pmc_pkg::PMC_ACTIVE;
					d.vld_finish = 1'h0;
				end else if (!vld_busy) begin
					d.vld_finish = 1'h0;
				end
			end
			pmc_pkg::PMC_SLEEP: begin
				// Only the pin and port A paths can end sleep
				if (pin_wake || pa_wake) begin
					d.mode = pmc_pkg::PMC_STARTUP;
					d.sleep_bit = 1'h0;
				end
			end
			pmc_pkg::PMC_STARTUP: begin
				if (startup_done) begin
					d.mode = pmc_pkg::PMC_ACTIVE;
				end
			end
			default: begin
				d.mode = pmc_pkg::PMC_ACTIVE;
			end
			endcase
		end
	end

	// Of the resets, power-on reset alone clears the arm latch; wake keeps it at 1
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign mode = q.mode;
	assign sleep_arm = q.sleep_arm;
	assign sleep_bit = q.sleep_bit;
	assign cpu_clk_en = in_active;
	assign periph_clk_en = in_active || in_standby;
	assign osc_en = !in_sleep;
	// Standby asserts no reset, so all state is retained
	assign sys_reset = in_sleep || in_startup;
	assign cpu_reset = in_sleep || in_startup;
	assign portb_sp_hiz = in_sleep;
	assign porta_in_en = !in_sleep || porta_reset_in_sleep;
	assign porta_pull_en = !in_sleep || porta_reset_in_sleep;
	assign vld_en = in_active || (in_standby && q.vld_finish);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_halt_to_standby: assert property (
		in_active && clk_en && halt_exec && !sys_reset_req &&
		!sleep_write_ok |=> mode == pmc_pkg::PMC_STANDBY)
		else $error("halt did not enter standby");

	a_standby_clocks: assert property (
		in_standby |-> !cpu_clk_en && periph_clk_en && osc_en)
		else $error("standby clock gating wrong");

	a_standby_retain: assert property (
		in_standby && clk_en && !sys_reset_req
		|=> !sys_reset && (sleep_arm == $past(sleep_arm) ||
		$past(wr_system_control_2)))
		else $error("standby disturbed state");

	a_standby_exit: assert property (
		in_standby && clk_en && (sys_reset_req || irq_pending)
		|=> !in_standby)
		else $error("standby not left on wake event");

	a_sleep_entry: assert property (
		in_active && clk_en && !sys_reset_req && sleep_write_ok
		|=> in_sleep && !osc_en && sleep_bit)
		else $error("armed sleep write did not sleep");

	a_sleep_unarmed: assert property (
		in_active && clk_en && !sleep_arm |=> !in_sleep)
		else $error("sleep entered without arm");

	a_pa_wake: assert property (
		in_sleep && clk_en && porta_reset_in_sleep && pa_match
		|=> in_startup)
		else $error("port A combination did not wake");

	a_sleep_reset: assert property (
		in_sleep || in_startup |-> sys_reset && cpu_reset)
		else $error("reset not held in sleep or start-up");

	a_wake_bits: assert property (
		in_sleep ##1 in_startup |-> sleep_arm && !sleep_bit)
		else $error("wake changed arm or kept sleep bit");

	a_sleep_pins: assert property (
		in_sleep |-> portb_sp_hiz &&
		porta_in_en == porta_reset_in_sleep)
		else $error("sleep pin state wrong");

	// An interrupt wake returns to active, where the detector runs
	a_vld_stop: assert property (
		in_standby && clk_en && !vld_busy && !irq_pending
		|=> !vld_en)
		else $error("level detector kept running");

	a_arm_hold: assert property (
		clk_en && !wr_system_control_2 |=> $stable(sleep_arm))
		else $error("arm bit changed without a write");

	a_irq_resume: assert property (
		in_standby && clk_en && irq_pending && !sys_reset_req
		|=> in_active && !cpu_reset && cpu_clk_en)
		else $error("interrupt wake did not resume");

	c_standby_irq: cover property (
		in_standby ##1 in_active);
	c_sleep_pin_wake: cover property (
		in_sleep && pin_wake ##1 in_startup);
	c_sleep_pa_wake: cover property (
		in_sleep && pa_wake ##1 in_startup);
	c_startup_done: cover property (
		in_startup ##1 in_active);

endmodule // pmc_power_mode_controller

// ### bench/pmc_cpu_model.sv
// Processor core model: halt instruction and control register writes
`timescale 1ns/10ps
module pmc_cpu_model (
	input wire logic clk_sys,
	output logic halt_exec,
	output logic wr_system_control_1,
	output logic wr_sleep_bit,
	output logic wr_system_control_2,
	output logic wr_sleep_arm
);
	initial begin
		halt_exec = 1'h0;
		wr_system_control_1 = 1'h0;
		wr_sleep_bit = 1'h1;
		wr_system_control_2 = 1'h0;
		wr_sleep_arm = 1'h1;
	end

	// ==========================================================
	// Requests
	task automatic halt();
		@(negedge clk_sys);
		halt_exec = 1'h1;
		@(negedge clk_sys);
		halt_exec = 1'h0;
	endtask

	// Idle data lines show the inverse, so a design that reads them
	// without the strobe goes wrong
	task automatic write_ctl(input logic to_arm, input logic v);
		@(negedge clk_sys);
		if (to_arm) begin
			wr_system_control_2 = 1'h1;
			wr_sleep_arm = v;
		end else begin
			wr_system_control_1 = 1'h1;
			wr_sleep_bit = v;
		end
		@(negedge clk_sys);
		wr_system_control_1 = 1'h0;
		wr_system_control_2 = 1'h0;
		if (to_arm) begin
			wr_sleep_arm = ~v;
		end else begin
			wr_sleep_bit = ~v;
		end
	endtask

	// Gap sets how promptly software follows the arm with the sleep write
	task automatic enter_sleep(input int gap);
		write_ctl(1'h1, 1'h1);
		repeat (gap) @(negedge clk_sys);
		write_ctl(1'h0, 1'h1);
	endtask
endmodule // pmc_cpu_model

// ### bench/testbench.sv
// Self-checking bench of the power mode controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	miscompares++; $display("wrong value %s exp %0h got %0h", nm, e, g); \
	end end
module testbench;
	localparam int SU = 8;
	logic clk_sys = 1'h0;
	logic arst_n, irq_pending, sys_reset_req, reset_pin, opt, vld_busy;
	logic clk_en;
	logic halt_exec, wr1, wr_bit, wr2, wr_arm;
	logic [3:0] porta_pin, sel1, sel2;
	pmc_pkg::pmc_mode_e mode;
	logic sleep_arm, sleep_bit, cpu_clk_en, periph_clk_en, osc_en;
	logic sys_reset, cpu_reset, hiz, pa_in, pa_pull, vld_en;
	int miscompares = 0;
	int n_compared = 0;

	always #2.5 clk_sys = ~clk_sys;

	pmc_cpu_model u_pmc_cpu_model (.clk_sys(clk_sys), .halt_exec(halt_exec),
		.wr_system_control_1(wr1), .wr_sleep_bit(wr_bit),
		.wr_system_control_2(wr2), .wr_sleep_arm(wr_arm));

	pmc_power_mode_controller #(.STARTUP_CYCLES(SU))
		u_pmc_power_mode_controller (.clk_sys(clk_sys), .arst_n(arst_n),
		.clk_en(clk_en), .halt_exec(halt_exec),
		.irq_pending(irq_pending),
		.sys_reset_req(sys_reset_req), .wr_system_control_1(wr1),
		.wr_sleep_bit(wr_bit), .wr_system_control_2(wr2),
		.wr_sleep_arm(wr_arm), .reset_pin(reset_pin), .porta_pin(porta_pin),
		.porta_sel1(sel1), .porta_sel2(sel2), .porta_reset_in_sleep(opt),
		.vld_busy(vld_busy), .mode(mode), .sleep_arm(sleep_arm),
		.sleep_bit(sleep_bit), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .osc_en(osc_en),
		.sys_reset(sys_reset), .cpu_reset(cpu_reset), .portb_sp_hiz(hiz),
		.porta_in_en(pa_in), .porta_pull_en(pa_pull), .vld_en(vld_en));

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic results();
		if (miscompares == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_standby();
		`CHK("arm", 1'h0, sleep_arm)
		vld_busy = 1'h1;
		u_pmc_cpu_model.halt();
		`CHK("mode", pmc_pkg::PMC_STANDBY, mode)
		`CHK("cpu clk", 1'h0, cpu_clk_en)
		`CHK("periph clk", 1'h1, periph_clk_en)
		`CHK("osc", 1'h1, osc_en)
		`CHK("vld", 1'h1, vld_en)
		vld_busy = 1'h0;
		cyc(3);
		`CHK("vld", 1'h0, vld_en)
		`CHK("reset", 1'h0, sys_reset)
		// A frozen clock enable must hold standby despite the interrupt
		clk_en = 1'h0;
		irq_pending = 1'h1;
		cyc(3);
		`CHK("frozen", pmc_pkg::PMC_STANDBY, mode)
		clk_en = 1'h1;
		cyc(1);
		irq_pending = 1'h0;
		`CHK("mode", pmc_pkg::PMC_ACTIVE, mode)
		`CHK("cpu reset", 1'h0, cpu_reset)
		`CHK("cpu clk", 1'h1, cpu_clk_en)
	endtask

	task automatic t_sleep_pin();
		int n;
		sel1 = 4'hF;
		sel2 = 4'hF;
		u_pmc_cpu_model.write_ctl(1'h0, 1'h1);
		`CHK("mode", pmc_pkg::PMC_ACTIVE, mode)
		u_pmc_cpu_model.enter_sleep(3);
		`CHK("mode", pmc_pkg::PMC_SLEEP, mode)
		`CHK("sleep", 1'h1, sleep_bit)
		`CHK("osc", 1'h0, osc_en)
		`CHK("periph", 1'h0, periph_clk_en)
		`CHK("rst", 1'h1, sys_reset & cpu_reset)
		`CHK("hiz", 1'h1, hiz)
		`CHK("pa", 1'h0, pa_in | pa_pull)
		// Short pin pulse, interrupt and open port A match must not wake
		irq_pending = 1'h1;
		reset_pin = 1'h1;
		cyc(1000);
		reset_pin = 1'h0;
		irq_pending = 1'h0;
		cyc(5);
		`CHK("mode", pmc_pkg::PMC_SLEEP, mode)
		reset_pin = 1'h1;
		n = 0;
		while (mode === pmc_pkg::PMC_SLEEP && n < 3000) begin
			cyc(1);
			n++;
		end
		reset_pin = 1'h0;
		`CHK("filter", 1'h1, n >= 2000 && n <= 2006)
		`CHK("mode", pmc_pkg::PMC_STARTUP, mode)
		`CHK("cpu reset", 1'h1, cpu_reset)
		`CHK("sleep", 1'h0, sleep_bit)
		n = 0;
		while (mode === pmc_pkg::PMC_STARTUP && n < 100) begin
			cyc(1);
			n++;
		end
		`CHK("hold", 1'h1, n == SU + 1)
		`CHK("mode", pmc_pkg::PMC_ACTIVE, mode)
		`CHK("arm", 1'h1, sleep_arm)
	endtask

	task automatic t_sleep_porta();
		int n;
		opt = 1'h1;
		sel1 = 4'hE;
		sel2 = 4'hF;
		u_pmc_cpu_model.enter_sleep(0);
		`CHK("pa", 1'h1, pa_in & pa_pull)
		cyc(20);
		`CHK("mode", pmc_pkg::PMC_SLEEP, mode)
		porta_pin = 4'h1;
		n = 0;
		while (mode === pmc_pkg::PMC_SLEEP && n < 10) begin
			cyc(1);
			n++;
		end
		porta_pin = 4'h0;
		`CHK("pa wake", 1'h1, n <= 4)
		`CHK("mode", pmc_pkg::PMC_STARTUP, mode)
		opt = 1'h0;
		cyc(SU + 1);
		`CHK("mode", pmc_pkg::PMC_ACTIVE, mode)
	endtask

	task automatic t_sysreset();
		u_pmc_cpu_model.halt();
		sys_reset_req = 1'h1;
		cyc(1);
		sys_reset_req = 1'h0;
		`CHK("mode", pmc_pkg::PMC_STARTUP, mode)
		`CHK("arm", 1'h1, sleep_arm)
	endtask

	initial begin
		arst_n = 1'h0;
		{irq_pending, sys_reset_req, reset_pin, opt, vld_busy} = 5'h0;
		clk_en = 1'h1;
		porta_pin = 4'h0;
		sel1 = 4'h0;
		sel2 = 4'h0;
		cyc(8);
		arst_n = 1'h1;
		cyc(1);
		t_standby();
		t_sleep_pin();
		t_sleep_porta();
		t_sysreset();
		results();
	end

	// Whole run needs some 3100 cycles
	initial begin
		cyc(20000);
		miscompares++;
		results();
	end
endmodule // testbench
